//--- logic/pll_clock_configuration.sv
// PLL setting store, clock enable generation, timer and clock blocks.
// Assumes clk is the synthesised clock; slower clocks are one-cycle enables.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_configuration
   import pll_clock_pkg::*;
#(
   parameter int OSC_KHZ = 25000,
   parameter int NUM_PORTS = 4,
   parameter int NUM_CLKBLK = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Board straps
   input wire logic [1:0] modePin,
   // PLL setting write and status
   input wire logic cfgWrite,
   input wire pll_cfg_s cfgData,
   output pll_cfg_s pllCfg,
   output logic [31:0] coreFreqKhz,
   output logic cfgOutOfRange,
   output logic pllSettled,
   // Derived clock enables and the timer
   output logic switchClkEn,
   output logic tileClkEn,
   output logic refClkEn,
   output logic [TIMER_WIDTH-1:0] timer,
   // Clock blocks
   input wire logic blkWrite,
   input wire logic [$clog2(NUM_CLKBLK)-1:0] blkIdx,
   input wire clkblk_cfg_s blkCfg,
   input wire logic [NUM_CLKBLK-1:0] clkBlkPin,
   output logic [NUM_CLKBLK-1:0] clkBlkEdge,
   output logic [NUM_CLKBLK-1:0] clkBlkPinOut,
   output logic [NUM_CLKBLK-1:0] clkBlkPinOe,
   // Port attachment
   input wire logic portSelWrite,
   input wire logic [$clog2(NUM_PORTS)-1:0] portSelIdx,
   input wire logic [$clog2(NUM_CLKBLK)-1:0] portSelBlk,
   output logic [NUM_PORTS-1:0] portClkEn
);

   function automatic pll_cfg_s strap_cfg(input logic [1:0] m);
      unique case (m)
         STRAP_00: strap_cfg = CFG_STRAP_00;
         STRAP_11: strap_cfg = CFG_STRAP_11;
         STRAP_10: strap_cfg = CFG_STRAP_10;
         STRAP_01: strap_cfg = CFG_STRAP_01;
      endcase
   endfunction

   // Intermediate frequency in kHz, before the output divider.
   function automatic longint vco_khz(input pll_cfg_s c);
      vco_khz = (longint'(OSC_KHZ) * (longint'(c.multiplier) + 1))
         / (2 * (longint'(c.refDivider) + 1));
   endfunction

   logic [1:0] modeMeta;
   logic [1:0] modeSync;
   logic strapTaken;
   logic [SETTLE_WIDTH-1:0] settleCnt;
   logic running;
   logic [OD_WIDTH-1:0] odCnt;
   logic [7:0] refCnt;
   logic [NUM_CLKBLK-1:0] pinMeta;
   logic [NUM_CLKBLK-1:0] pinSync;
   logic [NUM_CLKBLK-1:0] pinLast;
   clkblk_cfg_s blkState [NUM_CLKBLK];
   logic [CB_DIV_WIDTH-1:0] blkCnt [NUM_CLKBLK];
   logic [$clog2(NUM_CLKBLK)-1:0] portBlk [NUM_PORTS];
   logic anyPortWrite;
   logic anyBlkWrite;

   // Straps are asynchronous to clk, so they pass two flops first. These flops have no reset,
   // so the straps are through them by release; reset must span two clock edges for that.
   always_ff @(posedge clk) begin
      modeMeta <= modePin;
      modeSync <= modeMeta;
   end

   // The strap is caught once, after release, since reset may only load constants.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapTaken <= 1'b0;
         pllCfg <= CFG_RESET;
      end else if (!strapTaken) begin
         strapTaken <= 1'b1;
         pllCfg <= strap_cfg(modeSync);
      end else if (cfgWrite) begin
         pllCfg <= cfgData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coreFreqKhz <= 32'h0;
         cfgOutOfRange <= 1'b0;
      end else begin
         coreFreqKhz <= 32'(vco_khz(pllCfg) / (longint'(pllCfg.outputDivider) + 1));
         cfgOutOfRange <= (vco_khz(pllCfg) < VCO_MIN_KHZ) || (vco_khz(pllCfg) > VCO_MAX_KHZ);
      end
   end

   // Any new ratio restarts the hold, so no shortened pulse reaches a clock user.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settleCnt <= SETTLE_WIDTH'(LOCK_CYCLES);
      end else if (!strapTaken || cfgWrite) begin
         settleCnt <= SETTLE_WIDTH'(LOCK_CYCLES);
      end else if (settleCnt != '0) begin
         settleCnt <= settleCnt - 1'b1;
      end
   end

   assign running = strapTaken && (settleCnt == '0) && !cfgWrite;
   assign pllSettled = running;
   assign switchClkEn = running;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         odCnt <= '0;
      end else if (!running || odCnt >= pllCfg.outputDivider) begin
         odCnt <= '0;
      end else begin
         odCnt <= odCnt + 1'b1;
      end
   end
   assign tileClkEn = running && (odCnt >= pllCfg.outputDivider);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refCnt <= 8'h0;
      end else if (!running || refCnt == 8'(REF_CYCLES - 1)) begin
         refCnt <= 8'h0;
      end else begin
         refCnt <= refCnt + 8'h1;
      end
   end
   assign refClkEn = running && (refCnt == 8'(REF_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer <= '0;
      end else if (refClkEn) begin
         timer <= timer + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta <= '0;
         pinSync <= '0;
         pinLast <= '0;
      end else begin
         pinMeta <= clkBlkPin;
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   // Each block ticks on a pin rising edge or on every divide+1 reference ticks.
   for (genvar b = 0; b < NUM_CLKBLK; b++) begin : g_blk
      logic divTick;
      assign divTick = refClkEn && (blkCnt[b] >= blkState[b].divide);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            blkState[b] <= CB_RESET;
         end else if (blkWrite && blkIdx == b) begin
            blkState[b] <= blkCfg;
         end
      end
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            blkCnt[b] <= '0;
         end else if (divTick) begin
            blkCnt[b] <= '0;
         end else if (refClkEn) begin
            blkCnt[b] <= blkCnt[b] + 1'b1;
         end
      end
      assign clkBlkEdge[b] = blkState[b].useExtPin ? (pinSync[b] && !pinLast[b]) : divTick;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            clkBlkPinOut[b] <= 1'b0;
         end else if (clkBlkEdge[b]) begin
            clkBlkPinOut[b] <= !clkBlkPinOut[b];
         end
      end
      assign clkBlkPinOe[b] = blkState[b].driveOut;
   end

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            portBlk[p] <= '0;
         end else if (portSelWrite && portSelIdx == p) begin
            portBlk[p] <= portSelBlk;
         end
      end
      assign portClkEn[p] = clkBlkEdge[portBlk[p]];
   end

   // Helper flags that only the checks read.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         anyPortWrite <= 1'b0;
         anyBlkWrite <= 1'b0;
      end else begin
         anyPortWrite <= anyPortWrite || portSelWrite;
         anyBlkWrite <= anyBlkWrite || blkWrite;
      end
   end

   sequence s_write_taken;
      strapTaken && cfgWrite;
   endsequence
   sequence s_od1_tick;
      tileClkEn && running && pllCfg.outputDivider == 3'h1;
   endsequence

   property p_strap;
      @(posedge clk) disable iff (!rst_n)
      $rose(strapTaken) |-> pllCfg == strap_cfg($past(modeSync));
   endproperty
   a_strap: assert property (p_strap) else $error("strap settings not loaded");

   property p_write;
      @(posedge clk) disable iff (!rst_n)
      s_write_taken |=> pllCfg == $past(cfgData);
   endproperty
   a_write: assert property (p_write) else $error("PLL write not stored");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      s_write_taken |=> (!tileClkEn && !refClkEn && !switchClkEn) [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("clock enable during settling");

   property p_settle;
      @(posedge clk) disable iff (!rst_n)
      strapTaken && settleCnt != '0 && !cfgWrite |=> settleCnt == $past(settleCnt) - 1'b1;
   endproperty
   a_settle: assert property (p_settle) else $error("settle count not falling");

   property p_od;
      @(posedge clk) disable iff (!rst_n)
      s_od1_tick ##1 (running && !cfgWrite) |-> !tileClkEn ##1 (running ? tileClkEn : 1'b1);
   endproperty
   a_od: assert property (p_od) else $error("tile enable not every two cycles");

   property p_timer;
      @(posedge clk) disable iff (!rst_n)
      refClkEn |=> timer == $past(timer) + 1'b1;
   endproperty
   a_timer: assert property (p_timer) else $error("timer missed a tick");

   property p_timer_still;
      @(posedge clk) disable iff (!rst_n)
      !refClkEn |=> $stable(timer);
   endproperty
   a_timer_still: assert property (p_timer_still) else $error("timer moved without tick");

   property p_ref_src;
      @(posedge clk) disable iff (!rst_n)
      !switchClkEn |-> !tileClkEn && !refClkEn;
   endproperty
   a_ref_src: assert property (p_ref_src) else $error("reference tick without PLL");

   property p_port_default;
      @(posedge clk) disable iff (!rst_n)
      (!anyPortWrite && !anyBlkWrite) |-> portClkEn == {NUM_PORTS{refClkEn}};
   endproperty
   a_port_default: assert property (p_port_default) else $error("port not on block 0");

endmodule
`default_nettype wire

//--- logic/pll_clock_pkg.sv
// Constants and carrier types for the PLL clock configuration block.
// Assumes a single 50 MHz system clock that stands for the PLL output.
package pll_clock_pkg;

   // System clock period, used to turn times into cycle counts.
   localparam int CLK_PERIOD_NS = 20;

   // PLL setting fields and their legal upper limits.
   localparam int OD_WIDTH = 3;
   localparam int MUL_WIDTH = 12;
   localparam int REFDIV_WIDTH = 6;
   localparam int OD_MAX = 7;
   localparam int MUL_MAX = 4095;
   localparam int REFDIV_MAX = 63;

   typedef struct packed {
      logic [OD_WIDTH-1:0] outputDivider;
      logic [MUL_WIDTH-1:0] multiplier;
      logic [REFDIV_WIDTH-1:0] refDivider;
   } pll_cfg_s;

   // Strap patterns and the settings that each one selects.
   localparam logic [1:0] STRAP_00 = 2'h0;
   localparam logic [1:0] STRAP_01 = 2'h1;
   localparam logic [1:0] STRAP_10 = 2'h2;
   localparam logic [1:0] STRAP_11 = 2'h3;
   localparam pll_cfg_s CFG_STRAP_00 = '{3'h1, 12'h07a, 6'h00};
   localparam pll_cfg_s CFG_STRAP_11 = '{3'h2, 12'h077, 6'h00};
   localparam pll_cfg_s CFG_STRAP_10 = '{3'h2, 12'h031, 6'h00};
   localparam pll_cfg_s CFG_STRAP_01 = '{3'h2, 12'h017, 6'h00};
   localparam pll_cfg_s CFG_RESET = CFG_STRAP_00;

   // Legal window of the intermediate frequency, in kHz.
   localparam longint VCO_MIN_KHZ = 260000;
   localparam longint VCO_MAX_KHZ = 1300000;

   // Reference tick period and its cycle count, a longest time rounded down but never below one cycle.
   localparam int REF_TICK_NS = 10;
   localparam int REF_CYCLES_RAW = REF_TICK_NS / CLK_PERIOD_NS;
   localparam int REF_CYCLES = (REF_CYCLES_RAW < 1) ? 1 : REF_CYCLES_RAW;

   // Settling hold after a new ratio, a least time rounded up.
   localparam int LOCK_TIME_NS = 10000;
   localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Clock block configuration.
   localparam int CB_DIV_WIDTH = 8;
   typedef struct packed {
      logic useExtPin;
      logic driveOut;
      logic [CB_DIV_WIDTH-1:0] divide;
   } clkblk_cfg_s;
   localparam clkblk_cfg_s CB_RESET = '{1'b0, 1'b0, 8'h00};

   localparam int TIMER_WIDTH = 32;
   localparam int SETTLE_WIDTH = 16;

endpackage

//--- sim/board_model.sv
// Board-side partner: strap pins and an external clock source for clock block 1.
// Assumes the bench sets the strap pattern before reset and keeps it steady.
`timescale 1ns/1ps
`default_nettype none
module board_model (
   // Strap selection from the bench
   input wire logic [1:0] strapSel,
   // Pins seen by the device
   output logic [1:0] modePin,
   output logic [1:0] clkBlkPin
);
   // Straps are plain levels that follow the bench choice and move only while reset is held.
   assign modePin = strapSel;

   // The external clock stands still low between bursts, as a gated source would.
   initial begin
      clkBlkPin = 2'h0;
   end

   task automatic ext_burst(input int pulses);
      for (int i = 0; i < pulses; i++) begin
         clkBlkPin[1] = 1'b1;
         #60;
         clkBlkPin[1] = 1'b0;
         #60;
      end
   endtask
endmodule
`default_nettype wire

//--- sim/pll_clock_configuration_test.sv
// Self-checking bench for the PLL clock configuration block.
// Assumes OSC_KHZ of 25000 and two clock blocks; the board model drives straps.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_configuration_test;
   import pll_clock_pkg::*;

   logic clk, rst_n, cfgWrite, blkWrite, blkIdx, portSelWrite, portSelBlk;
   logic [1:0] strapSel, modePin, clkBlkPin, portSelIdx;
   logic [1:0] clkBlkEdge, clkBlkPinOut, clkBlkPinOe;
   logic [3:0] portClkEn;
   logic [31:0] coreFreqKhz, timer;
   logic cfgOutOfRange, pllSettled, switchClkEn, tileClkEn, refClkEn;
   pll_cfg_s cfgData, pllCfg;
   clkblk_cfg_s blkCfg;
   int error_cnt = 0;
   int checks = 0;
   int cycles = 0;
   int nSw, nTile, nRef, nPort0, nPort2, nEdge1, nToggle;

   board_model board (.strapSel(strapSel), .modePin(modePin), .clkBlkPin(clkBlkPin));

   pll_clock_configuration #(.OSC_KHZ(25000), .NUM_PORTS(4), .NUM_CLKBLK(2)) dut (
      .clk(clk), .rst_n(rst_n), .modePin(modePin), .cfgWrite(cfgWrite), .cfgData(cfgData),
      .pllCfg(pllCfg), .coreFreqKhz(coreFreqKhz), .cfgOutOfRange(cfgOutOfRange),
      .pllSettled(pllSettled), .switchClkEn(switchClkEn), .tileClkEn(tileClkEn),
      .refClkEn(refClkEn), .timer(timer), .blkWrite(blkWrite), .blkIdx(blkIdx),
      .blkCfg(blkCfg), .clkBlkPin(clkBlkPin), .clkBlkEdge(clkBlkEdge),
      .clkBlkPinOut(clkBlkPinOut), .clkBlkPinOe(clkBlkPinOe), .portSelWrite(portSelWrite),
      .portSelIdx(portSelIdx), .portSelBlk(portSelBlk), .portClkEn(portClkEn));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // The whole run needs about 3200 cycles; the ceiling leaves ample margin.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt = error_cnt + 1;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks = checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wait_settled(output int n);
      n = 0;
      while (pllSettled !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   // Counts every enable over a window, sampled once per cycle after the edge settles.
   task automatic count(input int len);
      logic lastPin;
      nSw = 0;
      nTile = 0;
      nRef = 0;
      nPort0 = 0;
      nPort2 = 0;
      nEdge1 = 0;
      nToggle = 0;
      lastPin = clkBlkPinOut[1];
      for (int i = 0; i < len; i++) begin
         @(posedge clk);
         #1;
         nSw += (switchClkEn === 1'b1);
         nTile += (tileClkEn === 1'b1);
         nRef += (refClkEn === 1'b1);
         nPort0 += (portClkEn[0] === 1'b1 && portClkEn[1] === 1'b1
                    && portClkEn[3] === 1'b1 && clkBlkEdge[0] === 1'b1);
         nPort2 += (portClkEn[2] === 1'b1);
         nEdge1 += (clkBlkEdge[1] === 1'b1);
         nToggle += (clkBlkPinOut[1] !== lastPin);
         lastPin = clkBlkPinOut[1];
      end
   endtask

   task automatic do_reset(input logic [1:0] pattern);
      int n;
      rst_n = 1'b0;
      strapSel = pattern;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      wait_settled(n);
      chk("settled after reset", 32'h1, 32'(pllSettled));
   endtask

   task automatic write_cfg(input pll_cfg_s c, input logic [31:0] khz, input logic flag);
      int n;
      @(posedge clk);
      #1;
      cfgWrite = 1'b1;
      cfgData = c;
      @(posedge clk);
      #1;
      cfgWrite = 1'b0;
      chk("pllCfg", 32'(c), 32'(pllCfg));
      chk("settled drop", 32'h0, 32'(pllSettled));
      chk("switch held", 32'h0, 32'(switchClkEn));
      wait_settled(n);
      chk("settle time ok", 32'h1, 32'(n >= LOCK_CYCLES - 1 && n <= LOCK_CYCLES + 1));
      chk("coreFreqKhz", khz, coreFreqKhz);
      chk("cfgOutOfRange", 32'(flag), 32'(cfgOutOfRange));
   endtask

   task automatic t_straps();
      pll_cfg_s expTab [4];
      expTab = '{'{3'h1, 12'h07a, 6'h00}, '{3'h2, 12'h017, 6'h00},
                 '{3'h2, 12'h031, 6'h00}, '{3'h2, 12'h077, 6'h00}};
      for (int p = 3; p >= 0; p--) begin
         do_reset(2'(p));
         chk("strap cfg", 32'(expTab[p]), 32'(pllCfg));
      end
   endtask

   task automatic t_ratio();
      logic [31:0] t0;
      // A divide-by-four tile clock makes the tile pulse spacing easy to count.
      write_cfg('{3'h3, 12'h03f, 6'h01}, 32'h000186a0, 1'b0);
      t0 = timer;
      count(40);
      chk("switch pulses", 32'd40, 32'(nSw));
      chk("tile pulses", 32'd10, 32'(nTile));
      chk("ref pulses", 32'd40, 32'(nRef));
      chk("timer step", 32'd40, timer - t0);
      // Too low an intermediate frequency is stored but flagged.
      write_cfg('{3'h0, 12'h001, 6'h00}, 32'h000061a8, 1'b1);
   endtask

   task automatic t_clkblk();
      count(40);
      chk("port0 on block0", 32'(40 / REF_CYCLES), 32'(nPort0));
      chk("block oe reset", 32'h0, 32'(clkBlkPinOe));
      @(posedge clk);
      #1;
      blkWrite = 1'b1;
      blkIdx = 1'b1;
      blkCfg = '{1'b0, 1'b1, 8'h03};
      portSelWrite = 1'b1;
      portSelIdx = 2'h2;
      portSelBlk = 1'b1;
      @(posedge clk);
      #1;
      blkWrite = 1'b0;
      portSelWrite = 1'b0;
      count(40);
      chk("block1 divided", 32'd10, 32'(nEdge1));
      chk("port2 paced", 32'd10, 32'(nPort2));
      chk("pin toggles", 32'd10, 32'(nToggle));
      chk("block oe", 32'h2, 32'(clkBlkPinOe));
      chk("ports left on block0", 32'(40 / REF_CYCLES), 32'(nPort0));
      @(posedge clk);
      #1;
      blkWrite = 1'b1;
      blkCfg = '{1'b1, 1'b0, 8'h00};
      @(posedge clk);
      #1;
      blkWrite = 1'b0;
      fork
         board.ext_burst(10);
         count(80);
      join
      chk("ext edges", 32'd10, 32'(nEdge1));
      chk("port2 ext", 32'd10, 32'(nPort2));
      chk("block oe off", 32'h0, 32'(clkBlkPinOe));
   endtask

   initial begin
      rst_n = 1'b0;
      strapSel = 2'h0;
      cfgWrite = 1'b0;
      cfgData = '0;
      blkWrite = 1'b0;
      blkIdx = 1'b0;
      blkCfg = '0;
      portSelWrite = 1'b0;
      portSelIdx = 2'h0;
      portSelBlk = 1'b0;
      t_straps();
      t_ratio();
      t_clkblk();
      wrap_up();
   end
endmodule
`default_nettype wire
